//--- core/blank_timer.sv
/*
 * blank_timer: delayed one-shot that marks the led blanking window.
 * assumes: start_i is a one-cycle pulse on clk_i; a new pulse restarts
 * the window.
 */
`timescale 1ns/1ps
module blank_timer
	import led_seq_pkg::*;
#(
	parameter int DELAY  = BLANK_DELAY,
	parameter int CYCLES = BLANK_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic start_i,
	output logic      busy_o
);

	// ------------------------------------------------------------
	// start delay line
	// ------------------------------------------------------------
	logic [DELAY-1:0] delay_line;
	logic [15:0]      remain;
	wire              launch = delay_line[DELAY-1];

	always_ff @(posedge clk_i) begin
		if (rst_i)
			delay_line <= '0;
		else
			delay_line <= {delay_line[DELAY-2:0], start_i};
	end

	// ------------------------------------------------------------
	// window counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remain <= 16'h0000;
			busy_o <= 1'b0;
		end else if (launch) begin
			remain <= 16'(CYCLES - 1);
			busy_o <= 1'b1;
		end else if (remain != 16'h0000) begin
			remain <= remain - 16'h0001;
		end else begin
			busy_o <= 1'b0;
		end
	end

endmodule : blank_timer

//--- core/led_seq_pkg.sv
/*
 * led_seq_pkg: shared constants, types and register map of the
 * led illumination sequencer.
 * assumes: a 40 MHz system clock and a 32-bit classic wishbone bus.
 */
package led_seq_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 40_000_000;
	localparam int BLANK_MIN_NS  = 25_000;
	// least time: round up to whole cycles
	localparam int BLANK_CYCLES  =
		(BLANK_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// the blank opens on the 3rd clock after the gate strobe rises, blank_o on the 4th
	localparam int BLANK_DELAY   = 2;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_SLOTS  = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// ctrl fields
	localparam int CTRL_MONO_BIT   = 0;
	localparam int CTRL_LAST_LSB   = 1;
	localparam int CTRL_BLANK_BIT  = 3;
	localparam int CTRL_WIDTH      = 4;
	// reset: colour mode, four states, blanking on
	localparam logic [3:0] CTRL_RESET  = 4'he;
	// slots: four 2-bit selections, slot 0 in bits 1:0
	localparam int SLOT_WIDTH      = 2;
	localparam int SLOT_COUNT      = 4;
	// reset: red, green, blue, off
	localparam logic [7:0] SLOTS_RESET = 8'he4;

	// status fields
	localparam int STAT_STATE_LSB  = 0;
	localparam int STAT_DONE_BIT   = 2;
	localparam int STAT_DRIVE_LSB  = 3;
	localparam int STAT_BLANK_BIT  = 6;
	localparam int STAT_FSM_LSB    = 7;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_RED   = 2'h0,
		SEL_GREEN = 2'h1,
		SEL_BLUE  = 2'h2,
		SEL_OFF   = 2'h3
	} led_sel_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_HOLD = 3'h4
	} seq_fsm_t;

	typedef struct packed {
		logic       blank_en;
		logic [1:0] last_state;
		logic       mono;
	} ctrl_t;

	typedef struct packed {
		logic blue;
		logic green;
		logic red;
	} led_drive_t;

endpackage : led_seq_pkg

//--- core/led_sequencer.sv
/*
 * led_sequencer: led illumination sequence machine with a classic
 * wishbone register slave.
 * assumes: strobes and period_end_i are synchronous to clk_i; the scan
 * timing controller pulses the transfer gate once per line in colour mode.
 */
`timescale 1ns/1ps
module led_sequencer
	import led_seq_pkg::*;
#(
	parameter int STATES      = SLOT_COUNT,
	parameter int BLANK_COUNT = BLANK_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// scan timing strobes
	input  wire logic        line_start_strobe_i,
	input  wire logic        transfer_gate_strobe_i,
	input  wire logic        period_end_i,
	// led drive
	output logic             led_red_o,
	output logic             led_green_o,
	output logic             led_blue_o,
	output logic             blank_o,
	output logic [1:0]       sequence_state_o,
	output logic             sequence_done_o
);

	// ------------------------------------------------------------
	// selection helpers
	// ------------------------------------------------------------
	function automatic led_sel_t slot_of(
		input logic [7:0] slots,
		input logic [1:0] idx
	);
		logic [1:0] raw;
		raw = slots[idx*SLOT_WIDTH +: SLOT_WIDTH];
		slot_of = led_sel_t'(raw);
	endfunction : slot_of

	function automatic logic is_reg(
		input logic [7:0] adr,
		input logic [7:0] off
	);
		is_reg = (adr[7:2] == off[7:2]);
	endfunction : is_reg

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	ctrl_t                  ctrl;
	logic [7:0]             slots;

	// ------------------------------------------------------------
	// sequence state
	// ------------------------------------------------------------
	seq_fsm_t               fsm;
	seq_fsm_t               next_fsm;
	logic [1:0]             sequence_state_counter;
	logic [1:0]             next_counter;
	logic                   tg_prev;
	logic                   blank_busy;
	led_drive_t             drive;
	led_drive_t             next_drive;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire bus_req    = wb_cyc_i & wb_stb_i;
	wire bus_commit = bus_req & wb_ack_o;
	wire wr_commit  = bus_commit & wb_we_i;
	wire hit_ctrl   = is_reg(wb_adr_i, ADDR_CTRL);
	wire hit_slots  = is_reg(wb_adr_i, ADDR_SLOTS);
	wire hit_status = is_reg(wb_adr_i, ADDR_STATUS);
	wire wr_ctrl    = wr_commit & hit_ctrl & wb_sel_i[0];
	wire wr_slots   = wr_commit & hit_slots & wb_sel_i[0];

	// ------------------------------------------------------------
	// strobe decode
	// ------------------------------------------------------------
	wire start_hit  = line_start_strobe_i
	                & transfer_gate_strobe_i;
	wire tg_rise    = transfer_gate_strobe_i & ~tg_prev;
	wire colour_adv = tg_rise
	                & ~line_start_strobe_i;
	// the end-of-enable input is the only mono trigger, no strobe needed
	wire mono_adv   = period_end_i;
	wire advance    = ctrl.mono ? mono_adv : colour_adv;
	wire at_last    = (sequence_state_counter
	                  == ctrl.last_state);
	// blanking is a colour feature; mono users clear blank_en
	wire blank_go   = tg_rise & ctrl.blank_en;

	// ------------------------------------------------------------
	// current selection
	// ------------------------------------------------------------
	led_sel_t cur_sel;
	assign cur_sel = slot_of(slots, sequence_state_counter);

	wire lit = (fsm == ST_RUN) & ~blank_busy;

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	logic [31:0] status_word;
	assign status_word = {
		22'h000000,
		fsm,
		blank_busy,
		drive,
		(fsm == ST_HOLD),
		sequence_state_counter
	};

	logic [31:0] rd_mux;
	assign rd_mux =
		hit_ctrl   ? {28'h0000000, ctrl} :
		hit_slots  ? {24'h000000, slots} :
		hit_status ? status_word :
		32'h00000000;

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	// ack one cycle after the request, dropped the cycle after; writes
	// land on the edge at which the master samples ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			wb_dat_o <= (bus_req & ~wb_ack_o) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl <= ctrl_t'(CTRL_RESET);
		else if (wr_ctrl)
			ctrl <= ctrl_t'(wb_dat_i[CTRL_WIDTH-1:0]);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			slots <= SLOTS_RESET;
		else if (wr_slots)
			slots <= wb_dat_i[7:0];
	end

	// ------------------------------------------------------------
	// sequence machine
	// ------------------------------------------------------------
	always_comb begin
		next_fsm     = fsm;
		next_counter = sequence_state_counter;
		case (fsm)
			ST_IDLE: begin
				if (start_hit) begin
					next_fsm     = ST_RUN;
					next_counter = 2'h0;
				end
			end
			ST_RUN: begin
				if (start_hit) begin
					// restart overrides any step in progress
					next_counter = 2'h0;
				end else if (advance) begin
					if (at_last)
						next_fsm = ST_HOLD;
					else
						next_counter =
							sequence_state_counter + 2'h1;
				end
			end
			ST_HOLD: begin
				// counter holds the last value, nothing wraps
				if (start_hit) begin
					next_fsm     = ST_RUN;
					next_counter = 2'h0;
				end
			end
			default: begin
				next_fsm     = ST_IDLE;
				next_counter = 2'h0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fsm                    <= ST_IDLE;
			sequence_state_counter <= 2'h0;
			tg_prev                <= 1'b0;
		end else begin
			fsm                    <= next_fsm;
			sequence_state_counter <= next_counter;
			tg_prev                <= transfer_gate_strobe_i;
		end
	end

	// ------------------------------------------------------------
	// blanking window
	// ------------------------------------------------------------
	// drive is shunted while the current dac settles
	blank_timer #(
		.DELAY  (BLANK_DELAY),
		.CYCLES (BLANK_COUNT)
	) u_blank (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (blank_go),
		.busy_o  (blank_busy)
	);

	// ------------------------------------------------------------
	// led drive decode
	// ------------------------------------------------------------
	// one compare per colour keeps the enables mutually exclusive
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_colour
			assign next_drive[g] = lit
				& (cur_sel == led_sel_t'(g));
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive            <= '0;
			led_red_o        <= 1'b0;
			led_green_o      <= 1'b0;
			led_blue_o       <= 1'b0;
			blank_o          <= 1'b0;
			sequence_state_o <= 2'h0;
			sequence_done_o  <= 1'b0;
		end else begin
			drive            <= next_drive;
			led_red_o        <= next_drive.red;
			led_green_o      <= next_drive.green;
			led_blue_o       <= next_drive.blue;
			blank_o          <= blank_busy;
			sequence_state_o <= next_counter;
			// in mono the hold is reached within one line
			sequence_done_o  <= (next_fsm == ST_HOLD);
		end
	end

endmodule : led_sequencer

//--- testbench/led_scan_ctl.sv
/* led_scan_ctl: behavioural scan timing controller for the sequencer.
 * assumes: the bench calls one task at a time, gap of at least 1. */
`timescale 1ns/1ps
module led_scan_ctl (
	input  wire logic	clk_i,
	output logic		line_start_o,
	output logic		gate_o,
	output logic		period_end_o
);
	// ------
	// drive
	// ------
	initial begin
		line_start_o = 1'h0;
		gate_o = 1'h0;
		period_end_o = 1'h0;
	end
	task automatic start();
		@(posedge clk_i);
		line_start_o <= 1'h1;
		gate_o <= 1'h1;
		@(posedge clk_i);
		line_start_o <= 1'h0;
		gate_o <= 1'h0;
	endtask : start
	// one gate pulse per line; gap sets prompt or slow lines
	task automatic gate(input int gap);
		repeat (gap) @(posedge clk_i);
		gate_o <= 1'h1;
		@(posedge clk_i);
		gate_o <= 1'h0;
	endtask : gate
	task automatic pulse();
		@(posedge clk_i);
		period_end_o <= 1'h1;
		@(posedge clk_i);
		period_end_o <= 1'h0;
	endtask : pulse
endmodule : led_scan_ctl

//--- testbench/led_sequencer_sva.sv
/* led_sequencer_sva: port checks of the led sequencer.
 * assumes: bound into led_sequencer, one clock, sync reset. */
`timescale 1ns/1ps
module led_sequencer_sva (
	input wire logic	clk_i,
	input wire logic	rst_i,
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_ack_o,
	input wire logic [31:0]	wb_dat_o,
	input wire logic	line_start_strobe_i,
	input wire logic	transfer_gate_strobe_i,
	input wire logic	period_end_i,
	input wire logic	led_red_o,
	input wire logic	led_green_o,
	input wire logic	led_blue_o,
	input wire logic	blank_o,
	input wire logic [1:0]	sequence_state_o,
	input wire logic	sequence_done_o
);
	// -------
	// checks
	// -------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic restart = line_start_strobe_i && transfer_gate_strobe_i;
	wire logic [2:0] drive = {led_blue_o, led_green_o, led_red_o};

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	drive_excl_a: assert property ($onehot0(drive))
		else $error("more than one led on");
	start_zero_a: assert property (restart |=>
		sequence_state_o == 2'h0 && !sequence_done_o)
		else $error("start did not load state zero");
	step_cause_a: assert property ($changed(sequence_state_o) |->
		$past(transfer_gate_strobe_i || period_end_i))
		else $error("state moved without a cause");
	step_one_a: assert property ($changed(sequence_state_o) &&
		!$past(restart) |-> sequence_state_o == $past(sequence_state_o) + 2'h1)
		else $error("state did not step by one");
	done_dark_a: assert property (sequence_done_o |=> drive == 3'h0)
		else $error("led on after final state");
	done_hold_a: assert property (sequence_done_o && !restart |=>
		sequence_done_o && $stable(sequence_state_o))
		else $error("final state left without start");
	blank_dark_a: assert property (blank_o |-> drive == 3'h0)
		else $error("led on while blanking");
endmodule : led_sequencer_sva

bind led_sequencer led_sequencer_sva chk_u (.*);

//--- testbench/led_sequencer_tb_top.sv
/* led_sequencer_tb_top: table driven bench of the led sequencer.
 * assumes: led_scan_ctl makes the strobes; blank count shortened to 8. */
`timescale 1ns/1ps
module led_sequencer_tb_top import led_seq_pkg::*;;
	// ------
	// setup
	// ------
	localparam int BLANK_N = 8;
	logic		clk_i = 1'h0;
	logic		rst_i = 1'h1;
	logic		cyc = 1'h0;
	logic		stb = 1'h0;
	logic		we = 1'h0;
	logic [7:0]	adr = 8'h0;
	logic [31:0]	wdat = 32'h0;
	logic [31:0]	rdat, q;
	logic		ack, ls, tg, pe, red, green, blue, blank, done;
	logic [1:0]	st;
	int		errors = 0;
	int		n_tests = 0;
	int		cycles = 0;
	// {ctrl, slots, action 0 start 1 gate 2 period, state, done bgr}
	logic [23:0]	rows [17] = '{24'h6e4001, 24'h6e4201, 24'h6e4112,
		24'h6e4124, 24'h6e4130, 24'h6e4138, 24'h6e4138, 24'h21b000,
		24'h21b114, 24'h21b118, 24'h21b000, 24'h5e4001, 24'h5e4212,
		24'h5e4224, 24'h5e4228, 24'h5e4228, 24'h5e4001};

	always #12.5 clk_i = ~clk_i;
	led_sequencer #(.BLANK_COUNT(BLANK_N)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .line_start_strobe_i(ls),
		.transfer_gate_strobe_i(tg), .period_end_i(pe), .led_red_o(red),
		.led_green_o(green), .led_blue_o(blue), .blank_o(blank),
		.sequence_state_o(st), .sequence_done_o(done));
	led_scan_ctl ctl_u (.clk_i(clk_i), .line_start_o(ls), .gate_o(tg),
		.period_end_o(pe));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'h1) @(posedge clk_i);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : wb
	task automatic results();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	// hang guard: the whole run needs well under 1000 cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			results();
		end
	end

	// ------
	// tests
	// ------
	initial begin
		repeat (5) @(posedge clk_i);
		chk({25'h0, red, green, blue, blank, st, done}, 32'h0);
		rst_i <= 1'h0;
		wb(1'h0, ADDR_CTRL, 32'h0);
		chk(q, {28'h0, CTRL_RESET});
		wb(1'h0, ADDR_SLOTS, 32'h0);
		chk(q, {24'h0, SLOTS_RESET});
		wb(1'h1, ADDR_STATUS, 32'h3ff);
		wb(1'h0, ADDR_STATUS, 32'h0);
		chk(q, 32'h80);
		wb(1'h1, 8'h0c, 32'hff);
		wb(1'h0, 8'h0c, 32'h0);
		chk(q, 32'h0);
		$display("registers done");
		foreach (rows[i]) begin
			if (rows[i][11:8] == 4'h0) begin
				wb(1'h1, ADDR_CTRL, {28'h0, rows[i][23:20]});
				wb(1'h1, ADDR_SLOTS, {24'h0, rows[i][19:12]});
				ctl_u.start();
			end else if (rows[i][11:8] == 4'h1) ctl_u.gate(1);
			else ctl_u.pulse();
			@(negedge clk_i);
			chk({29'h0, done, st}, {29'h0, rows[i][3], rows[i][5:4]});
			@(negedge clk_i);
			chk({29'h0, blue, green, red}, {29'h0, rows[i][2:0]});
			$display("row %0d done", i);
		end
		wb(1'h0, ADDR_STATUS, 32'h0);
		chk(q, 32'h108);
		wb(1'h1, ADDR_CTRL, 32'he);
		ctl_u.start();
		ctl_u.gate(12);
		repeat (3) @(negedge clk_i);
		chk(32'(blank), 32'h0);
		@(negedge clk_i);
		chk(32'(blank), 32'h1);
		repeat (BLANK_N - 1) @(negedge clk_i);
		chk(32'(blank), 32'h1);
		@(negedge clk_i);
		chk(32'(blank), 32'h0);
		$display("blanking done");
		results();
	end
endmodule : led_sequencer_tb_top
